/* core/lpmc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_defines.svh"
// What this block does
// - stop stops clocks, keeps ram and registers
// - stop disables pll, fast and multispeed oscillators; regulator low-power
// - any enabled event line wakes stop, 8us
// - sixteen lines or supply monitor wake stop
// - comparator wake only while reference is on
// - usb wakeup also ends stop
// - standby with clock: core off, slow oscillator on
// - standby loses core state, standby domain kept
// - standby with clock exit sources, within 60us
// - standby without clock: reset pin, wake pins
// - standby without clock: all oscillators off unless clock or watchdog run
// - clock and watchdog run unless software stops
// - sleep halts core, peripherals keep running
// - low-power modes: no fast oscillators, multispeed
// - slow oscillators run through stop only while clock or watchdog run
// - monitors always operational; clock, wake timer run while software enables
// - pins float during and after reset
module lpmc_top #(
  parameter int STBY_EXIT_CYC = `LPMC_STBY_EXIT_CYC
) (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire lpmc_pkg::lpmc_wake_t WAKE_IN,
  output logic IRQ,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic CORE_PWR_EN,
  output logic REG_LOWPWR,
  output logic RETAIN,
  output logic CORE_RESET,
  output var lpmc_pkg::lpmc_osc_t OSC_EN,
  output logic RTC_RUN,
  output logic WDG_RUN,
  output logic MON_EN,
  output logic GPIO_FLOAT
);

  lpmc_pkg::lpmc_state_t state_q, state_d;
  lpmc_pkg::lpmc_wake_t wk;
  logic [5:0] cnt_q;
  logic [2:0] ctrl_q;
  logic vref_q;
  logic [2:0] aon_q;
  logic go_q;
  logic [19:0] wen_q;
  logic [2:0] irq_st_q, irq_mask_q, irq_ev;
  logic [4:0] csr_q;
  logic [2:0] pin_prev_q;
  logic [2:0] pin_rise;
  logic stop_wake, stby_wake, core_clr;
  logic wr_go, wr_fire, rd_go, rd_fire;
  logic [2:0] wr_idx;
  logic [31:0] wr_val, wr_ones;
  logic run_full, run_lp, keep_slow;

  function automatic logic [2:0] reg_index(input logic [7:0] a);
    if (a == `LPMC_CTRL_OFF) begin
      return 3'h0;
    end else if (a == `LPMC_WEN_OFF) begin
      return 3'h1;
    end else if (a == `LPMC_STAT_OFF) begin
      return 3'h2;
    end else if (a == `LPMC_IRQ_ST_OFF) begin
      return 3'h3;
    end else if (a == `LPMC_IRQ_MASK_OFF) begin
      return 3'h4;
    end else if (a == `LPMC_CSR_OFF) begin
      return 3'h5;
    end else begin
      return 3'h7;
    end
  endfunction

  function automatic logic [31:0] reg_word(input logic [2:0] idx);
    case (idx)
      // go and mode read back as zero
      3'h0: return {23'h0, ~GPIO_FLOAT, aon_q[2:1], vref_q, aon_q[0], 4'h0};
      3'h1: return {12'h0, wen_q};
      3'h2: return {22'h0, OSC_EN, state_q};
      3'h3: return {29'h0, irq_st_q};
      3'h4: return {29'h0, irq_mask_q};
      3'h5: return {27'h0, csr_q};
      default: return 32'h0;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // wake inputs come straight from pins and other clock domains
  lpmc_sync #(.W(30), .INIT(`LPMC_SYNC_INIT)) u_sync (
    .clk(CLK_SYS),
    .rst(RESET),
    .d(WAKE_IN),
    .q(wk)
  );

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      pin_prev_q <= 3'h0;
    end else begin
      pin_prev_q <= wk.pin;
    end
  end

  assign pin_rise = wk.pin & ~pin_prev_q;

  // comparator paths gated by reference enable
  assign stop_wake = |(wk.ext & wen_q[15:0]) | (wk.mon & wen_q[`LPMC_W_MON])
                   | (wk.usb & wen_q[`LPMC_W_USB])
                   | (vref_q & ((wk.cmp1 & wen_q[`LPMC_W_CMP1])
                   | (wk.cmp2 & wen_q[`LPMC_W_CMP2])));

  // clock-domain sources only count when the clock is kept in standby
  assign stby_wake = ~wk.rst_n | (|pin_rise)
                   | (aon_q[0] & (wk.wdg | (|wk.rtc)));

  assign core_clr = (state_q == lpmc_pkg::S_STBY) || (state_q == lpmc_pkg::S_RESTART);

  always_comb begin
    state_d = state_q;
    case (state_q)
      lpmc_pkg::S_RUN, lpmc_pkg::S_LPRUN: begin
        if (go_q) begin
          case (lpmc_pkg::lpmc_mode_t'(ctrl_q))
            lpmc_pkg::MODE_RUN: state_d = lpmc_pkg::S_RUN;
            lpmc_pkg::MODE_SLEEP: state_d = lpmc_pkg::S_SLEEP;
            lpmc_pkg::MODE_LPRUN: state_d = lpmc_pkg::S_LPRUN;
            lpmc_pkg::MODE_LPSLEEP: state_d = lpmc_pkg::S_LPSLEEP;
            lpmc_pkg::MODE_STOP: state_d = lpmc_pkg::S_STOP;
            lpmc_pkg::MODE_STBY: state_d = lpmc_pkg::S_STBY;
            default: state_d = state_q;
          endcase
        end
      end
      lpmc_pkg::S_SLEEP: if (stop_wake) state_d = lpmc_pkg::S_RUN;
      lpmc_pkg::S_LPSLEEP: if (stop_wake) state_d = lpmc_pkg::S_LPRUN;
      lpmc_pkg::S_STOP: if (stop_wake) state_d = lpmc_pkg::S_STOP_WAKE;
      lpmc_pkg::S_STOP_WAKE: if (cnt_q == `LPMC_SETTLE_CYC) state_d = lpmc_pkg::S_RUN;
      lpmc_pkg::S_STBY: if (stby_wake) state_d = lpmc_pkg::S_RESTART;
      lpmc_pkg::S_RESTART: if (cnt_q == `LPMC_RESTART_CYC) state_d = lpmc_pkg::S_RUN;
      default: state_d = lpmc_pkg::S_RUN;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      state_q <= lpmc_pkg::S_RUN;
      cnt_q <= 6'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= (state_d != state_q) ? 6'h0 : cnt_q + 6'h1;
    end
  end

  // bus slave: address and data are taken together, one access at a time
  assign wr_go = AWVALID && WVALID && !AWREADY && !BVALID;
  assign wr_fire = AWREADY && AWVALID && WREADY && WVALID;
  assign rd_go = ARVALID && !ARREADY && !RVALID;
  assign rd_fire = ARREADY && ARVALID;
  // a process, so that register reads inside the functions are tracked
  always_comb begin
    wr_idx = reg_index(AWADDR);
    wr_val = merge(reg_word(wr_idx), WDATA, WSTRB);
    wr_ones = merge(32'h0, WDATA, WSTRB);
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `LPMC_RESP_OKAY;
    end else begin
      AWREADY <= wr_go;
      WREADY <= wr_go;
      if (wr_fire) begin
        BVALID <= 1'b1;
        BRESP <= (wr_idx == 3'h7) ? `LPMC_RESP_DECERR : `LPMC_RESP_OKAY;
      end else if (BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h0;
      RRESP <= `LPMC_RESP_OKAY;
    end else begin
      ARREADY <= rd_go;
      if (rd_fire) begin
        RVALID <= 1'b1;
        RDATA <= reg_word(reg_index(ARADDR));
        RRESP <= (reg_index(ARADDR) == 3'h7) ? `LPMC_RESP_DECERR : `LPMC_RESP_OKAY;
      end else if (RREADY) begin
        RVALID <= 1'b0;
      end
    end
  end

  // core-domain configuration is lost whenever the core is powered down
  always_ff @(posedge CLK_SYS) begin
    if (RESET || core_clr) begin
      ctrl_q <= `LPMC_CTRL_RST;
      vref_q <= 1'b0;
      go_q <= 1'b0;
      wen_q <= `LPMC_WEN_RST;
      irq_mask_q <= 3'h0;
    end else begin
      go_q <= 1'b0;
      if (wr_fire && wr_idx == 3'h0) begin
        ctrl_q <= wr_val[`LPMC_C_MODE_LSB +: 3];
        vref_q <= wr_val[`LPMC_C_VREF];
        go_q <= wr_val[`LPMC_C_GO];
      end
      if (wr_fire && wr_idx == 3'h1) begin
        wen_q <= wr_val[19:0];
      end
      if (wr_fire && wr_idx == 3'h4) begin
        irq_mask_q <= wr_val[2:0];
      end
    end
  end

  // standby-domain settings survive standby, only power-on clears them
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      aon_q <= `LPMC_AON_RST;
    end else if (wr_fire && wr_idx == 3'h0) begin
      aon_q <= {wr_val[`LPMC_C_WDG_RUN], wr_val[`LPMC_C_RTC_RUN], wr_val[`LPMC_C_RTC_STBY]};
    end
  end

  always_comb begin
    irq_ev = 3'h0;
    irq_ev[`LPMC_I_STOP] = (state_q == lpmc_pkg::S_STOP) && stop_wake;
    irq_ev[`LPMC_I_STBY] = (state_q == lpmc_pkg::S_RESTART) && (cnt_q == `LPMC_RESTART_CYC);
    irq_ev[`LPMC_I_SLEEP] = ((state_q == lpmc_pkg::S_SLEEP) || (state_q == lpmc_pkg::S_LPSLEEP))
                            && stop_wake;
  end

  // set wins over a same-cycle write-one-to-clear
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      irq_st_q <= 3'h0;
    end else begin
      if (core_clr) begin
        irq_st_q <= 3'h0;
      end else if (wr_fire && wr_idx == 3'h3) begin
        irq_st_q <= irq_st_q & ~wr_ones[2:0];
      end
      if (irq_ev != 3'h0) begin
        irq_st_q <= (core_clr ? 3'h0 : irq_st_q & ~((wr_fire && wr_idx == 3'h3) ?
                     wr_ones[2:0] : 3'h0)) | irq_ev;
      end
    end
  end

  // retained exit cause: flag, reset pin, watchdog, wake pin, clock event
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      csr_q <= 5'h0;
    end else if (state_q == lpmc_pkg::S_STBY && stby_wake) begin
      csr_q <= csr_q | {aon_q[0] & (|wk.rtc), |pin_rise, aon_q[0] & wk.wdg, ~wk.rst_n, 1'b1};
    end else if (wr_fire && wr_idx == 3'h5) begin
      csr_q <= csr_q & ~wr_ones[4:0];
    end
  end

  assign run_full = (state_q == lpmc_pkg::S_RUN) || (state_q == lpmc_pkg::S_SLEEP);
  assign run_lp = (state_q == lpmc_pkg::S_LPRUN) || (state_q == lpmc_pkg::S_LPSLEEP);
  // slow oscillators stay up while anything in the standby domain needs them
  assign keep_slow = run_full || run_lp || state_q == lpmc_pkg::S_STOP_WAKE
                   || core_clr && aon_q[0] || aon_q[1] || aon_q[2];

  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      CPU_CLK_EN <= 1'b0;
      PERIPH_CLK_EN <= 1'b0;
      CORE_PWR_EN <= 1'b1;
      REG_LOWPWR <= 1'b0;
      RETAIN <= 1'b0;
      CORE_RESET <= 1'b1;
      OSC_EN <= '0;
      RTC_RUN <= 1'b0;
      WDG_RUN <= 1'b0;
      MON_EN <= 1'b1;
      IRQ <= 1'b0;
    end else begin
      CPU_CLK_EN <= (state_q == lpmc_pkg::S_RUN) || (state_q == lpmc_pkg::S_LPRUN);
      PERIPH_CLK_EN <= run_full || run_lp;
      CORE_PWR_EN <= (state_q != lpmc_pkg::S_STBY);
      REG_LOWPWR <= (state_q == lpmc_pkg::S_STOP);
      RETAIN <= (state_q == lpmc_pkg::S_STOP);
      CORE_RESET <= core_clr;
      OSC_EN.pll <= run_full;
      OSC_EN.fast_int <= run_full;
      OSC_EN.fast_xtal <= run_full;
      OSC_EN.multispeed_internal_osc <= run_full || run_lp || state_q == lpmc_pkg::S_STOP_WAKE
                    || state_q == lpmc_pkg::S_RESTART;
      OSC_EN.slow_int <= keep_slow;
      OSC_EN.slow_xtal <= keep_slow;
      RTC_RUN <= aon_q[1];
      WDG_RUN <= aon_q[2];
      MON_EN <= 1'b1;
      IRQ <= |(irq_st_q & irq_mask_q);
    end
  end

  // pins float until software releases them after every restart
  always_ff @(posedge CLK_SYS) begin
    if (RESET || core_clr) begin
      GPIO_FLOAT <= 1'b1;
    end else if (wr_fire && wr_idx == 3'h0 && wr_val[`LPMC_C_GPIO_REL]) begin
      GPIO_FLOAT <= 1'b0;
    end
  end

  localparam int STOP_WAKE_MAX = `LPMC_STOP_WAKE_CYC;
  localparam int RESTART_MAX = 34;
  logic [12:0] exit_cnt_q;

  always_ff @(posedge CLK_SYS) begin
    if (RESET || state_q == lpmc_pkg::S_RUN) begin
      exit_cnt_q <= 13'h0;
    end else if (state_q == lpmc_pkg::S_RESTART) begin
      exit_cnt_q <= exit_cnt_q + 13'h1;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);

  sequence seq_stop_woken;
    state_q == lpmc_pkg::S_STOP && stop_wake ##1 state_q == lpmc_pkg::S_STOP_WAKE;
  endsequence

  chk_stop_wake_time: assert property (seq_stop_woken |-> ##[1:STOP_WAKE_MAX]
    state_q == lpmc_pkg::S_RUN) else $error("stop wakeup too slow");
  chk_stop_retain: assert property (state_q == lpmc_pkg::S_STOP |=> RETAIN &&
    CORE_PWR_EN && !CPU_CLK_EN && !PERIPH_CLK_EN) else $error("stop lost state");
  chk_stop_osc_off: assert property (state_q == lpmc_pkg::S_STOP |=>
    REG_LOWPWR && !OSC_EN.pll && !OSC_EN.multispeed_internal_osc && !OSC_EN.fast_int) else $error("stop osc on");
  chk_stop_hold: assert property (state_q == lpmc_pkg::S_STOP && !stop_wake |=>
    state_q == lpmc_pkg::S_STOP) else $error("stop left without wake");
  chk_stby_power: assert property (state_q == lpmc_pkg::S_STBY && aon_q[0] |=>
    !CORE_PWR_EN && OSC_EN.slow_int && !OSC_EN.pll) else $error("standby power wrong");
  chk_stby_exit_time: assert property (state_q == lpmc_pkg::S_STBY && stby_wake
    |-> ##[1:RESTART_MAX] state_q == lpmc_pkg::S_RUN) else $error("standby exit slow");
  chk_stby_exit_cap: assert property (exit_cnt_q < STBY_EXIT_CYC)
    else $error("standby exit exceeds limit");
  chk_stby_restart: assert property (state_q == lpmc_pkg::S_RESTART |=>
    CORE_RESET && GPIO_FLOAT) else $error("standby exit without restart");
  chk_sleep_core: assert property (state_q == lpmc_pkg::S_SLEEP |=>
    !CPU_CLK_EN && PERIPH_CLK_EN && OSC_EN.fast_int) else $error("sleep clocks wrong");
  chk_lp_fast_off: assert property (state_q == lpmc_pkg::S_LPRUN |=>
    !OSC_EN.fast_int && !OSC_EN.fast_xtal && OSC_EN.multispeed_internal_osc) else $error("fast osc in lp");
  chk_gpio_float: assert property ($fell(RESET) |-> GPIO_FLOAT)
    else $error("pins not floating after reset");

endmodule

`default_nettype wire

/* common/lpmc_defines.svh */
`ifndef LPMC_DEFINES_SVH
`define LPMC_DEFINES_SVH

// register byte offsets
`define LPMC_CTRL_OFF 8'h00
`define LPMC_WEN_OFF 8'h04
`define LPMC_STAT_OFF 8'h08
`define LPMC_IRQ_ST_OFF 8'h0c
`define LPMC_IRQ_MASK_OFF 8'h10
`define LPMC_CSR_OFF 8'h14

// control fields
`define LPMC_C_MODE_LSB 0
`define LPMC_C_GO 3
`define LPMC_C_RTC_STBY 4
`define LPMC_C_VREF 5
`define LPMC_C_RTC_RUN 6
`define LPMC_C_WDG_RUN 7
`define LPMC_C_GPIO_REL 8

// wake enable fields
`define LPMC_W_MON 16
`define LPMC_W_CMP1 17
`define LPMC_W_CMP2 18
`define LPMC_W_USB 19

// interrupt status fields
`define LPMC_I_STOP 0
`define LPMC_I_STBY 1
`define LPMC_I_SLEEP 2

// reset values
`define LPMC_CTRL_RST 3'h0
`define LPMC_AON_RST 3'h6
`define LPMC_WEN_RST 20'h00000
`define LPMC_SYNC_INIT 30'h0080_0000

// timing
`define LPMC_CLK_NS 10
`define LPMC_STOP_WAKE_NS 8000
`define LPMC_STOP_WAKE_CYC (`LPMC_STOP_WAKE_NS / `LPMC_CLK_NS)
`define LPMC_STBY_EXIT_NS 60000
`define LPMC_STBY_EXIT_CYC (`LPMC_STBY_EXIT_NS / `LPMC_CLK_NS)
`define LPMC_SETTLE_CYC 6'd16
`define LPMC_RESTART_CYC 6'd32

`define LPMC_RESP_OKAY 2'h0
`define LPMC_RESP_DECERR 2'h3

`endif

/* common/lpmc_pkg.sv */
`default_nettype none
package lpmc_pkg;

  typedef enum logic [2:0] {
    MODE_RUN = 3'b000,
    MODE_SLEEP = 3'b001,
    MODE_LPRUN = 3'b010,
    MODE_LPSLEEP = 3'b011,
    MODE_STOP = 3'b100,
    MODE_STBY = 3'b101
  } lpmc_mode_t;

  typedef enum logic [3:0] {
    S_RUN = 4'b0000,
    S_SLEEP = 4'b0001,
    S_LPRUN = 4'b0010,
    S_LPSLEEP = 4'b0011,
    S_STOP = 4'b0100,
    S_STOP_WAKE = 4'b0101,
    S_STBY = 4'b0110,
    S_RESTART = 4'b0111
  } lpmc_state_t;

  typedef struct packed {
    logic pll;
    logic fast_int;
    logic fast_xtal;
    logic multispeed_internal_osc;
    logic slow_int;
    logic slow_xtal;
  } lpmc_osc_t;

  typedef struct packed {
    logic [4:0] rtc;
    logic wdg;
    logic rst_n;
    logic [2:0] pin;
    logic usb;
    logic cmp2;
    logic cmp1;
    logic mon;
    logic [15:0] ext;
  } lpmc_wake_t;

endpackage
`default_nettype wire

/* core/lpmc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module lpmc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule

`default_nettype wire

/* tb/lpmc_wake_model.sv */
`timescale 1ns/1ps
`default_nettype none
// far-side wake sources: one source asserted at a time for a chosen hold
module lpmc_wake_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [4:0] src,
  input wire logic [7:0] hold,
  output wire lpmc_pkg::lpmc_wake_t wake
);
  logic [29:0] act_q;
  logic [7:0] cnt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      act_q <= 30'h0;
      cnt_q <= 8'h00;
    end else if (fire) begin
      act_q <= 30'h1 << src;
      cnt_q <= hold;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) act_q <= 30'h0;
    end
  end
  // one source high per pulse; reset pin bit inverted so it idles high
  assign wake = lpmc_pkg::lpmc_wake_t'(act_q ^ 30'h0080_0000);
endmodule
`default_nettype wire

/* tb/tb_low_power_mode_controller.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_defines.svh"
module tb_low_power_mode_controller;
  localparam int STBY_CYC = 100;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic fire = 1'h0;
  logic [4:0] src = 5'h00;
  logic [7:0] hold = 8'h03;
  logic awready, wready, bvalid, arready, rvalid, irq, cpu, per, pwr, lowp, ret, crst;
  logic rtc, wdg, mon, gflt;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  logic [31:0] lf = 32'hf6fe649f;
  lpmc_pkg::lpmc_osc_t osc;
  wire lpmc_pkg::lpmc_wake_t wake;
  int errors = 0;
  int samples_checked = 0;

  always #5 clk = ~clk;

  lpmc_top #(.STBY_EXIT_CYC(STBY_CYC)) dut_u (
    .CLK_SYS(clk), .RESET(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
    .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready), .WAKE_IN(wake),
    .IRQ(irq), .CPU_CLK_EN(cpu), .PERIPH_CLK_EN(per), .CORE_PWR_EN(pwr), .REG_LOWPWR(lowp),
    .RETAIN(ret), .CORE_RESET(crst), .OSC_EN(osc), .RTC_RUN(rtc), .WDG_RUN(wdg),
    .MON_EN(mon), .GPIO_FLOAT(gflt));
  lpmc_wake_model wake_u (.clk(clk), .rst(rst), .fire(fire), .src(src), .hold(hold),
    .wake(wake));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // oscillator enables in struct order: pll, fast pair, multispeed, slow pair
  function automatic logic [5:0] xosc(input logic f, input logic m, input logic s);
    return {f, f, f, m, s, s};
  endfunction

  task automatic end_sim;
    if (errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic timeout;
    errors++;
    $display("unexpected at %0t: wait bound used up", $time);
    end_sim();
  endtask
  task automatic cmp_w(input logic [31:0] g, input logic [31:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask
  task automatic cmp_f(input logic [5:0] g, input logic [5:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: pin %s got %b want %b", $time, m, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1 && bready) begin
        r = bresp;
        bready <= 1'h0;
      end
    end while ((awvalid || wvalid || bready) && n < 50);
    if (n >= 50) timeout();
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1 && rready) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
      end
    end while ((arvalid || rready) && n < 50);
    if (n >= 50) timeout();
  endtask
  task automatic go(input logic [31:0] c);
    wr(`LPMC_CTRL_OFF, c);
    tick(4);
  endtask
  // slow and prompt sources alike: the hold is drawn at random
  task automatic pulse(input int s);
    lf = lfsr(lf);
    src <= 5'(s);
    hold <= 8'h03 + 8'(lf[2:0]);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
  endtask
  task automatic wake_up(input int s, input int lim, input logic must, output logic saw);
    int n;
    pulse(s);
    n = 1;
    saw = 1'h0;
    while (!(cpu === 1'h1 && crst === 1'h0) && n < lim) begin
      @(posedge clk);
      n++;
      // core held in reset with power back on: the restart phase, not standby itself
      if (crst === 1'h1 && pwr === 1'h1) saw = 1'h1;
    end
    if (must && n >= lim) timeout();
  endtask
  task automatic stop_case(input int s, input logic [31:0] en, input logic [31:0] c,
                           input logic ok);
    logic saw;
    wr(`LPMC_WEN_OFF, en | 32'h1);
    wr(`LPMC_IRQ_MASK_OFF, {31'h0, c[6]});
    go(c | 32'h0c);
    cmp_f(cpu, 1'h0, "cpu");
    cmp_f(per, 1'h0, "per");
    cmp_f(ret, 1'h1, "ret");
    cmp_f(lowp, 1'h1, "lowp");
    cmp_f(osc, xosc(1'h0, 1'h0, |c[7:6]), "osc");
    cmp_f({rtc, wdg}, c[7:6] == 2'h3 ? 2'h3 : {c[6], c[7]}, "rtc wdg");
    wake_up(s, ok ? `LPMC_STOP_WAKE_CYC : 40, ok, saw);
    cmp_f(cpu, ok, "wake");
    if (!ok) wake_up(0, `LPMC_STOP_WAKE_CYC, 1'h1, saw);
    rd(`LPMC_WEN_OFF);
    cmp_w(d, en | 32'h1, "kept");
    rd(`LPMC_IRQ_ST_OFF);
    cmp_w(d, 32'h1, "irq st");
    cmp_f(irq, c[6], "irq");
    wr(`LPMC_IRQ_ST_OFF, 32'h1);
    tick(2);
    cmp_f(irq, 1'h0, "irq clr");
  endtask
  task automatic stby_case(input logic [31:0] c, input int bad, input int s,
                           input logic [31:0] cause);
    logic saw;
    wr(`LPMC_WEN_OFF, 32'h5);
    go(c | 32'h0d);
    cmp_f(pwr, 1'h0, "pwr");
    cmp_f(osc, xosc(1'h0, 1'h0, |c[7:4]), "osc");
    cmp_f({rtc, mon}, {c[6], 1'h1}, "rtc mon");
    if (bad < 30) begin
      wake_up(bad, 40, 1'h0, saw);
      cmp_f(pwr, 1'h0, "no exit");
    end
    wake_up(s, STBY_CYC, 1'h1, saw);
    cmp_f(saw, 1'h1, "restart");
    cmp_f(gflt, 1'h1, "float");
    rd(`LPMC_WEN_OFF);
    cmp_w(d, 32'h0, "lost");
    rd(`LPMC_CTRL_OFF);
    cmp_w(d, c & 32'hd0, "kept");
    rd(`LPMC_CSR_OFF);
    cmp_w(d, cause, "cause");
    rd(`LPMC_IRQ_ST_OFF);
    cmp_w(d, 32'h2, "irq st");
    wr(`LPMC_CSR_OFF, 32'h1f);
    wr(`LPMC_IRQ_ST_OFF, 32'h7);
  endtask

  initial begin
    int k;
    logic saw;
    tick(3);
    cmp_f({gflt, crst}, 2'h3, "in reset");
    tick(2);
    rst <= 1'h0;
    tick(2);
    cmp_f(gflt, 1'h1, "float");
    cmp_f(rtc & wdg & mon, 1'h1, "aon");
    cmp_f(osc, xosc(1'h1, 1'h1, 1'h1), "osc");
    rd(`LPMC_CTRL_OFF);
    cmp_w(d, 32'hc0, "ctrl");
    rd(8'h18);
    cmp_w({r, d[29:0]}, 32'hc000_0000, "unmapped rd");
    wr(8'h18, 32'hffff_ffff);
    cmp_w(r, 2'h3, "unmapped wr");
    wr(`LPMC_CTRL_OFF, 32'h1c0);
    cmp_f(gflt, 1'h0, "release");
    wr(`LPMC_WEN_OFF, 32'h1);
    go(32'hc9);
    cmp_f({cpu, per}, 2'h1, "sleep");
    cmp_f(osc, xosc(1'h1, 1'h1, 1'h1), "osc");
    wake_up(0, `LPMC_STOP_WAKE_CYC, 1'h1, saw);
    rd(`LPMC_IRQ_ST_OFF);
    cmp_w(d, 32'h4, "irq st");
    wr(`LPMC_IRQ_ST_OFF, 32'h4);
    go(32'hca);
    cmp_f(osc, xosc(1'h0, 1'h1, 1'h1), "lp osc");
    go(32'hcb);
    cmp_w({25'h0, cpu, osc}, {25'h0, 1'h0, xosc(1'h0, 1'h1, 1'h1)}, "lp sleep");
    wake_up(0, `LPMC_STOP_WAKE_CYC, 1'h1, saw);
    rd(`LPMC_STAT_OFF);
    cmp_w(d, {22'h0, xosc(1'h0, 1'h1, 1'h1), 4'h2}, "lp run");
    go(32'hc8);
    rd(`LPMC_STAT_OFF);
    cmp_w(d, {22'h0, xosc(1'h1, 1'h1, 1'h1), 4'h0}, "run");
    wr(`LPMC_IRQ_ST_OFF, 32'h7);
    lf = lfsr(lf);
    k = 1 + int'(lf % 15);
    stop_case((k % 15) + 1, 32'h1 << k, 32'h00, 1'h0);
    stop_case(k, 32'h1 << k, 32'h00, 1'h1);
    stop_case(16, 32'h1 << 16, 32'hc0, 1'h1);
    stop_case(19, 32'h1 << 19, 32'h40, 1'h1);
    stop_case(17, 32'h1 << 17, 32'h00, 1'h0);
    stop_case(17, 32'h1 << 17, 32'h20, 1'h1);
    stop_case(18, 32'h1 << 18, 32'ha0, 1'h1);
    lf = lfsr(lf);
    stby_case(32'hd0, 31, 25 + int'(lf % 5), 32'h11);
    stby_case(32'hd0, 31, 24, 32'h05);
    lf = lfsr(lf);
    stby_case(32'h00, 25 + int'(lf % 5), 20 + int'(lf % 3), 32'h09);
    stby_case(32'h00, 24, 23, 32'h03);
    end_sim();
  end

  initial begin
    #500000;
    timeout();
  end
endmodule
`default_nettype wire
